//--- include/pfs_defs.svh
// Offsets, field positions, reset values, key values and timing counts of the flash sequencer
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

`define PFS_CTRL_OFFSET 16'h0760
`define PFS_KEY_OFFSET 16'h0766
`define PFS_CTRL_RESET 16'h0000

`define PFS_BIT_START 15
`define PFS_BIT_OP_WRITE_ENABLE 14
`define PFS_BIT_ERR 13
`define PFS_BIT_ERASE 6
`define PFS_OP_MSB 3

`define PFS_OP_ROW_PROG 4'h1
`define PFS_OP_PAGE_ERASE 4'h2
`define PFS_KEY_FIRST 8'h55
`define PFS_KEY_SECOND 8'haa

// Program address units: two per instruction, 128 per row, 8 rows per page
`define PFS_ROW_ADDR_BITS 7
`define PFS_PAGE_ADDR_BITS 10
`define PFS_ROW_WORDS 64

// Array busy times in clock cycles
`define PFS_ERASE_CYCLES 4000
`define PFS_PROG_CYCLES 1000

`endif

//--- include/pfs_pkg.sv
// Types shared by the flash sequencer and its environment
package pfs_pkg;

   // Processor register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pfs_reg_req_type;

   // Table write into the row latches
   typedef struct packed {
      logic wr;
      logic [7:0] page;
      logic [15:0] offs;
      logic [23:0] data;
   } pfs_tbl_req_type;

   // Command toward the flash array
   typedef struct packed {
      logic erase;
      logic prog;
      logic [23:0] addr;
      logic [23:0] data;
   } pfs_flash_cmd_type;

   typedef enum logic [1:0] {
      PFS_IDLE = 2'b00,
      PFS_ERASE = 2'b01,
      PFS_PROG = 2'b10,
      PFS_WAIT = 2'b11
   } pfs_state_type;

   typedef enum logic [1:0] {
      PFS_KEY_NONE = 2'b00,
      PFS_KEY_HALF = 2'b01,
      PFS_KEY_OPEN = 2'b10
   } pfs_key_type;

endpackage

//--- logic/pfs_sequencer.sv
// Program flash erase and row program sequencer with key unlock and processor stall
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_sequencer #(
   parameter int unsigned ERASE_CYCLES = `PFS_ERASE_CYCLES,
   parameter int unsigned PROG_CYCLES = `PFS_PROG_CYCLES,
   parameter int unsigned ROW_WORDS = `PFS_ROW_WORDS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sys_reset,
   input wire pfs_pkg::pfs_reg_req_type reg_req,
   output logic [15:0] reg_rdata,
   input wire pfs_pkg::pfs_tbl_req_type tbl_req,
   output logic cpu_stall,
   output pfs_pkg::pfs_flash_cmd_type flash_cmd
);

   localparam int IW = $clog2(ROW_WORDS);

   // Clear the low address bits to reach a row or page boundary
   function automatic logic [23:0] pfs_align(input logic [23:0] a, input int unsigned bits);
      logic [23:0] m;
      m = ~((24'h000001 << bits) - 24'h000001);
      return a & m;
   endfunction

   pfs_pkg::pfs_state_type state_q;
   pfs_pkg::pfs_key_type key_q;
   logic wr_q;
   logic op_write_enable_q;
   logic err_q;
   logic erase_q;
   logic [3:0] op_q;
   logic [15:0] timer_q;
   logic [IW-1:0] idx_q;
   logic [23:0] base_q;
   logic [23:0] latch_mem [ROW_WORDS];
   logic [15:0] rdata_q;
   logic stall_q;
   pfs_pkg::pfs_flash_cmd_type cmd_q;

   logic [15:0] ctrl_val;
   logic ctrl_wr;
   logic key_wr;
   logic start_req;
   logic op_valid;
   logic start_go;
   logic busy;
   logic abort;

   assign ctrl_val = {wr_q, op_write_enable_q, err_q, 6'h00, erase_q, 2'b00, op_q};
   assign ctrl_wr = reg_req.wr && reg_req.addr == `PFS_CTRL_OFFSET;
   assign key_wr = reg_req.wr && reg_req.addr == `PFS_KEY_OFFSET;
   assign start_req = ctrl_wr && reg_req.wdata[`PFS_BIT_START];
   assign busy = state_q != pfs_pkg::PFS_IDLE;
   assign abort = sys_reset && busy;

   // Operation settings come from this same write, so 0x4042 plus start works in one go
   assign op_valid = reg_req.wdata[`PFS_BIT_OP_WRITE_ENABLE] &&
      ((reg_req.wdata[`PFS_OP_MSB:0] == `PFS_OP_PAGE_ERASE && reg_req.wdata[`PFS_BIT_ERASE]) ||
       (reg_req.wdata[`PFS_OP_MSB:0] == `PFS_OP_ROW_PROG && !reg_req.wdata[`PFS_BIT_ERASE]));

   // Start only straight after both keys, from idle, with a legal operation
   assign start_go = start_req && key_q == pfs_pkg::PFS_KEY_OPEN && op_valid && !busy && !sys_reset;

   ////////////////////////////////////////////////////////////////////////////
   // Unlock key tracking: any other register write breaks the sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         key_q <= pfs_pkg::PFS_KEY_NONE;
      end else if (ce) begin
         if (sys_reset) begin
            key_q <= pfs_pkg::PFS_KEY_NONE;
         end else if (key_wr && reg_req.wdata[7:0] == `PFS_KEY_FIRST) begin
            key_q <= pfs_pkg::PFS_KEY_HALF;
         end else if (key_wr && reg_req.wdata[7:0] == `PFS_KEY_SECOND && key_q == pfs_pkg::PFS_KEY_HALF) begin
            key_q <= pfs_pkg::PFS_KEY_OPEN;
         end else if (reg_req.wr) begin
            key_q <= pfs_pkg::PFS_KEY_NONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register; only power-on reset clears it, a system reset keeps fields
   always_ff @(posedge clk) begin
      if (rst) begin
         {wr_q, op_write_enable_q, err_q, erase_q, op_q} <= 8'h00;
      end else if (ce) begin
         if (abort) begin
            wr_q <= 1'b0;
            err_q <= 1'b1;
         end else if (busy && state_q == pfs_pkg::PFS_WAIT && timer_q == 16'h0000) begin
            wr_q <= 1'b0;
         end else if (ctrl_wr && !busy) begin
            op_write_enable_q <= reg_req.wdata[`PFS_BIT_OP_WRITE_ENABLE];
            erase_q <= reg_req.wdata[`PFS_BIT_ERASE];
            op_q <= reg_req.wdata[`PFS_OP_MSB:0];
            err_q <= err_q & reg_req.wdata[`PFS_BIT_ERR]; // Software may only clear it
            wr_q <= start_go;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Table writes fill row latches and record the target base; locked out while busy
   always_ff @(posedge clk) begin
      if (rst) begin
         base_q <= 24'h000000;
      end else if (ce && tbl_req.wr && !busy) begin
         base_q <= {tbl_req.page, tbl_req.offs};
      end
   end

   always_ff @(posedge clk) begin
      if (ce && tbl_req.wr && !busy) begin
         latch_mem[tbl_req.offs[IW:1]] <= tbl_req.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle sequencer; the processor stays stalled from start until the end
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= pfs_pkg::PFS_IDLE;
         timer_q <= 16'h0000;
         idx_q <= '0;
      end else if (ce) begin
         if (abort) begin
            state_q <= pfs_pkg::PFS_IDLE;
         end else begin
            unique case (state_q)
               pfs_pkg::PFS_IDLE: begin
                  idx_q <= '0;
                  if (start_go && reg_req.wdata[`PFS_BIT_ERASE]) begin
                     state_q <= pfs_pkg::PFS_ERASE;
                  end else if (start_go) begin
                     state_q <= pfs_pkg::PFS_PROG;
                  end
               end
               pfs_pkg::PFS_ERASE: begin
                  timer_q <= 16'(ERASE_CYCLES - 1);
                  state_q <= pfs_pkg::PFS_WAIT;
               end
               pfs_pkg::PFS_PROG: begin
                  idx_q <= IW'(idx_q + 1'b1);
                  if (idx_q == IW'(ROW_WORDS - 1)) begin
                     timer_q <= 16'(PROG_CYCLES - 1);
                     state_q <= pfs_pkg::PFS_WAIT;
                  end
               end
               pfs_pkg::PFS_WAIT: begin
                  if (timer_q == 16'h0000) begin
                     state_q <= pfs_pkg::PFS_IDLE;
                  end else begin
                     timer_q <= timer_q - 16'h0001;
                  end
               end
            endcase
         end
      end
   end

   // Stall spans the whole cycle, including the launch cycle after the start write
   always_ff @(posedge clk) begin
      if (rst) begin
         stall_q <= 1'b0;
      end else if (ce) begin
         stall_q <= start_go || (busy && !abort &&
            !(state_q == pfs_pkg::PFS_WAIT && timer_q == 16'h0000));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Array commands: one erase pulse per page, one program pulse per row word
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_q <= '0;
      end else if (ce) begin
         cmd_q.erase <= state_q == pfs_pkg::PFS_ERASE && !abort;
         cmd_q.prog <= state_q == pfs_pkg::PFS_PROG && !abort;
         if (state_q == pfs_pkg::PFS_ERASE) begin
            cmd_q.addr <= pfs_align(base_q, `PFS_PAGE_ADDR_BITS);
            cmd_q.data <= 24'h000000;
         end else begin
            cmd_q.addr <= pfs_align(base_q, `PFS_ROW_ADDR_BITS) | 24'({idx_q, 1'b0});
            // Zero outside row programming; during it every latch word goes to the array side, written or not
            cmd_q.data <= (state_q == pfs_pkg::PFS_PROG) ? latch_mem[idx_q] : 24'h000000;
         end
      end
   end

   // Read data one cycle after the strobe; the key register reads as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= `PFS_CTRL_RESET;
      end else if (ce && reg_req.rd) begin
         rdata_q <= (reg_req.addr == `PFS_CTRL_OFFSET) ? ctrl_val : 16'h0000;
      end
   end

   assign reg_rdata = rdata_q;
   assign cpu_stall = stall_q;
   assign flash_cmd = cmd_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [7:0] prog_cnt_q;
   always_ff @(posedge clk) begin
      if (rst || (ce && state_q == pfs_pkg::PFS_IDLE)) begin
         prog_cnt_q <= 8'h00;
      end else if (ce && cmd_q.prog) begin
         prog_cnt_q <= prog_cnt_q + 8'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);

   sequence s_launch;
      ##1 (busy && stall_q && wr_q);
   endsequence

   sequence s_release;
      ##1 (!wr_q && !stall_q && !busy);
   endsequence

   chk_locked_start: assert property (
      (start_req && key_q != pfs_pkg::PFS_KEY_OPEN && !busy) |=> (!wr_q && !busy && !cmd_q.erase)
   ) else $error("start without keys was not ignored");

   chk_key_order: assert property (
      (key_q == pfs_pkg::PFS_KEY_NONE && key_wr && reg_req.wdata[7:0] == `PFS_KEY_SECOND) |=>
         key_q == pfs_pkg::PFS_KEY_NONE
   ) else $error("second key alone opened the lock");

   chk_start_stall: assert property (start_go |-> s_launch) else $error("start did not stall");

   chk_erase_select: assert property (
      (start_go && reg_req.wdata[`PFS_BIT_ERASE]) |=> ##1 (cmd_q.erase && cmd_q.addr[`PFS_PAGE_ADDR_BITS-1:0] == '0)
   ) else $error("erase pulse missing or misaligned");

   chk_prog_select: assert property (
      (start_go && !reg_req.wdata[`PFS_BIT_ERASE]) |=> ##1 (cmd_q.prog && cmd_q.addr[`PFS_ROW_ADDR_BITS-1:0] == '0)
   ) else $error("program did not begin at row start");

   chk_row_length: assert property (
      ($past(state_q) == pfs_pkg::PFS_PROG && state_q == pfs_pkg::PFS_WAIT) |=>
         (prog_cnt_q == 8'(ROW_WORDS) && !cmd_q.prog)
   ) else $error("row program wrote a wrong word count");

   chk_self_clear: assert property (
      (state_q == pfs_pkg::PFS_WAIT && timer_q == 16'h0000 && !sys_reset) |-> s_release
   ) else $error("start bit did not clear at cycle end");

   chk_abort_flag: assert property (
      abort |=> (err_q && !wr_q && !busy) [*2]
   ) else $error("early end did not raise error flag");

   chk_por_value: assert property (disable iff (1'b0) rst |=> ctrl_val == `PFS_CTRL_RESET)
      else $error("control not cleared by power-on reset");

   // Start bit and stall rise and fall on the same edges
   chk_stall_track: assert property (stall_q == wr_q)
      else $error("stall and start bit disagree");

   // Only a software write while idle may drop the error flag
   chk_err_hold: assert property (
      (err_q && !(ctrl_wr && !busy)) |=> err_q
   ) else $error("error flag dropped on its own");

   // A stalled processor cannot retune the operation under way
   chk_busy_lock: assert property (
      (busy && ctrl_wr) |=> ($stable(op_q) && $stable(erase_q) && $stable(op_write_enable_q))
   ) else $error("control fields changed while busy");

   // The erase base must not move while the array is being worked on
   chk_table_lock: assert property (
      (busy && tbl_req.wr) |=> $stable(base_q)
   ) else $error("table write taken while busy");

   // One erase pulse per page; a second would wear the array for nothing
   chk_erase_single: assert property (
      cmd_q.erase |=> !cmd_q.erase
   ) else $error("erase pulse longer than one cycle");

endmodule

//--- verif/pfs_array_model.sv
// Flash array stand-in that tallies erase and program pulses
`timescale 1ns/1ps
module pfs_array_model (
   input wire logic clk,
   input wire logic clr,
   input wire pfs_pkg::pfs_flash_cmd_type cmd,
   output int n_erase,
   output int n_prog,
   output logic [23:0] erase_addr,
   output logic [23:0] prog_addr,
   output logic [23:0] prog_data,
   output logic seq_err
);
   // A skipped word would corrupt the row, so steps other than 2 are flagged
   always_ff @(posedge clk) begin
      if (clr) begin
         n_erase <= 0;
         n_prog <= 0;
         seq_err <= 1'b0;
      end else begin
         if (cmd.erase) begin
            n_erase <= n_erase + 1;
            erase_addr <= cmd.addr;
            n_prog <= 0;
         end
         if (cmd.prog) begin
            n_prog <= n_prog + 1;
            prog_addr <= cmd.addr;
            prog_data <= cmd.data;
            if (n_prog != 0 && cmd.addr != prog_addr + 24'h000002) begin
               seq_err <= 1'b1;
            end
         end
      end
   end
endmodule

//--- verif/tb_pfs_sequencer.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "pfs_defs.svh"
module tb_pfs_sequencer;
   localparam int unsigned EC = 8;
   localparam int unsigned PC = 6;
   localparam logic [15:0] CA = `PFS_CTRL_OFFSET;
   localparam logic [15:0] KA = `PFS_KEY_OFFSET;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic sys_reset = 1'b0;
   logic clr = 1'b1;
   pfs_pkg::pfs_reg_req_type rq = '0;
   pfs_pkg::pfs_tbl_req_type tq = '0;
   pfs_pkg::pfs_flash_cmd_type cmd;
   logic [15:0] rdata;
   logic stall;
   int n_erase;
   int n_prog;
   logic [23:0] e_addr;
   logic [23:0] p_addr;
   logic [23:0] p_data;
   logic seq_err;
   int n_fail = 0;
   int cmp_count = 0;
   logic [15:0] v;
   int n;
   ////////////////////////////////////////////////////////////////
   // Design and array stand-in; short busy times keep the run brief
   pfs_sequencer #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC), .ROW_WORDS(64)) dut (.clk(clk), .rst(rst),
      .ce(ce), .sys_reset(sys_reset), .reg_req(rq), .reg_rdata(rdata), .tbl_req(tq),
      .cpu_stall(stall), .flash_cmd(cmd));
   pfs_array_model arr (.clk(clk), .clr(clr), .cmd(cmd), .n_erase(n_erase), .n_prog(n_prog),
      .erase_addr(e_addr), .prog_addr(p_addr), .prog_data(p_data), .seq_err(seq_err));
   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // Reporting
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // Bus tasks start and end on a falling edge, one strobe per call
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      rq = '{1'b1, 1'b0, a, d};
      @(negedge clk);
      rq = '0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a);
      rq = '{1'b0, 1'b1, a, 16'h0000};
      @(negedge clk);
      rq = '0;
      repeat (2) @(negedge clk);
      v = rdata;
   endtask
   task automatic tw(input logic [15:0] of, input logic [23:0] d);
      tq = '{1'b1, 8'h01, of, d};
      @(negedge clk);
      tq = '0;
      @(negedge clk);
   endtask
   // Bounded wait on the stall level; n returns the cycles spent
   task automatic wait_stall(input logic lvl, input int max);
      n = 0;
      while (stall !== lvl && n < max) begin
         @(negedge clk);
         n++;
      end
      if (stall !== lvl) begin
         chk("cpu_stall wait", 24'(stall), 24'(lvl));
         end_of_test();
      end
   endtask
   task automatic go(input logic [15:0] c);
      wr(KA, 16'h0055);
      wr(KA, 16'h00aa);
      wr(CA, c);
   endtask
   ////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      rd(CA);
      chk("ctrl reset", 24'(v), 24'h000000);
      rd(KA);
      chk("key read", 24'(v), 24'h000000);
      rd(16'h0770);
      chk("unmapped", 24'(v), 24'h000000);
   endtask
   task automatic t_erase();
      wr(CA, 16'h4042);
      tw(16'h0456, 24'h000000);
      go(16'hc042);
      wait_stall(1'b1, 4);
      wait_stall(1'b0, EC + 20);
      // Stall spans launch plus EC wait cycles; one of them is past when counting starts
      chk("erase time", 24'(n), 24'(EC));
      chk("erase count", 24'(n_erase), 24'h000001);
      chk("erase addr", e_addr, 24'h010400);
      rd(CA);
      chk("start clear", 24'(v), 24'h004042);
   endtask
   task automatic t_prog();
      for (int i = 0; i < 64; i++) begin
         tw(16'h0400 + 16'(2 * i), 24'ha50000 + 24'(i));
      end
      wr(CA, 16'h4001);
      go(16'hc001);
      wait_stall(1'b1, 4);
      wait_stall(1'b0, 64 + PC + 20);
      // Stall spans 64 word cycles plus PC wait cycles, less the one already past
      chk("prog time", 24'(n), 24'(63 + PC));
      chk("prog count", 24'(n_prog), 24'h000040);
      chk("prog addr", p_addr, 24'h01047e);
      chk("prog data", p_data, 24'ha5003f);
      chk("prog order", 24'(seq_err), 24'h000000);
      rd(CA);
      chk("start clear", 24'(v), 24'h004001);
   endtask
   task automatic t_refuse();
      logic [7:0] ka [5] = '{8'haa, 8'h55, 8'h55, 8'h55, 8'h55};
      logic [7:0] kb [5] = '{8'h55, 8'h55, 8'haa, 8'haa, 8'haa};
      logic [15:0] op [5] = '{16'hc042, 16'hc042, 16'hc002, 16'hc041, 16'hc042};
      for (int i = 0; i < 5; i++) begin
         wr(KA, {8'h00, ka[i]});
         if (i == 4) begin
            wr(CA, 16'h4042);
         end
         wr(KA, {8'h00, kb[i]});
         wr(CA, op[i]);
         repeat (4) @(negedge clk);
         chk("no stall", 24'(stall), 24'h000000);
         chk("erases", 24'(n_erase), 24'h000001);
         chk("progs", 24'(n_prog), 24'h000040);
         rd(CA);
         chk("start refused", 24'(v), 24'(op[i] & 16'h7fff));
      end
   endtask
   task automatic t_abort();
      go(16'hc042);
      wait_stall(1'b1, 4);
      sys_reset = 1'b1;
      @(negedge clk);
      sys_reset = 1'b0;
      wait_stall(1'b0, 3);
      chk("erase count", 24'(n_erase), 24'h000003);
      chk("table lock", e_addr, 24'h010400);
      rd(CA);
      chk("abort flag", 24'(v), 24'h006042);
      wr(CA, 16'h6042);
      rd(CA);
      chk("flag kept", 24'(v), 24'h006042);
      wr(CA, 16'h4042);
      sys_reset = 1'b1;
      @(negedge clk);
      sys_reset = 1'b0;
      rd(CA);
      chk("flag cleared", 24'(v), 24'h004042);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd(CA);
      chk("por clear", 24'(v), 24'h000000);
   endtask
   // Erase with writes refused while busy and four edges frozen by the clock enable
   task automatic t_freeze();
      go(16'hc042);
      wr(CA, 16'h4001);
      tw(16'h0000, 24'h000000);
      ce = 1'b0;
      repeat (4) @(negedge clk);
      ce = 1'b1;
      wait_stall(1'b0, EC + 20);
      // Frozen edges move the stall's end to falling edge EC + 6; counting starts at the tenth
      chk("frozen time", 24'(n), 24'(EC - 4));
      chk("erase count", 24'(n_erase), 24'h000002);
      rd(CA);
      chk("busy write", 24'(v), 24'h004042);
   endtask
   // Main sequence, driven on falling edges
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      clr = 1'b0;
      t_reset();
      t_erase();
      t_prog();
      t_refuse();
      t_freeze();
      t_abort();
      end_of_test();
   end
endmodule
